// >>> verilog/dmtw_pkg.sv
// shared constants and types of the dual mode timer and watchdog
package dmtw_pkg;
    // counting arrangement of the two 32-bit halves
    typedef enum logic [1:0] {
        DMTW_MODE_64,
        DMTW_MODE_UNCHAINED,
        DMTW_MODE_CHAINED
    } dmtw_mode_t;

    localparam int DMTW_HALF_W = 32;
    localparam int DMTW_WD_W = 64;
    localparam logic [31:0] DMTW_HALF_RST = 32'h0000_0000;
    localparam logic [31:0] DMTW_HALF_ONE = 32'h0000_0001;
    localparam logic [31:0] DMTW_HALF_MAX = 32'hFFFF_FFFF;
    localparam logic [63:0] DMTW_WD_RST = 64'h0000_0000_0000_0000;
    localparam logic [63:0] DMTW_WD_ONE = 64'h0000_0000_0000_0001;
endpackage : dmtw_pkg

// >>> verilog/dmtw_half_if.sv
// bundle between the timer core and one 32-bit counting half
`timescale 1ns/10ps
`default_nettype none
interface dmtw_half_if;
    logic tick;
    logic clear;
    logic [31:0] period;
    logic [31:0] count;
    logic atPeriod;

    modport ctl (output tick, output clear, output period, input count, input atPeriod);
    modport cnt (input tick, input clear, input period, output count, output atPeriod);
endinterface : dmtw_half_if
`default_nettype wire

// >>> verilog/dmtw_half_counter.sv
// one 32-bit counting half with clear and period compare
`timescale 1ns/10ps
`default_nettype none
module dmtw_half_counter (
    input wire logic core_clk,
    input wire logic resetn,
    dmtw_half_if.cnt half
);
    logic [31:0] count_ff;
    logic [31:0] nxt_count;

    // clear beats tick so a match reloads to zero
    assign nxt_count = half.clear ? dmtw_pkg::DMTW_HALF_RST :
                       half.tick ? count_ff + dmtw_pkg::DMTW_HALF_ONE : count_ff; // RULE11
    assign half.count = count_ff;
    assign half.atPeriod = (count_ff == half.period);

    // count register
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_ff <= dmtw_pkg::DMTW_HALF_RST;
        end else begin
            count_ff <= nxt_count;
        end
    end

    a_clear_to_zero: assert property (@(posedge core_clk) disable iff (!resetn) // RULE11
        half.clear |=> count_ff == dmtw_pkg::DMTW_HALF_RST)
        else $error("half counter not zero after clear");
endmodule : dmtw_half_counter
`default_nettype wire

// >>> verilog/dmtw_timer_top.sv
// dual mode 64-bit timer with 32-bit halves and a 64-bit watchdog
// Functional notes
// RULE1: 64-bit counter, splittable into two 32-bit halves
// RULE2: modes: 64-bit, unchained dual, chained dual
// RULE3: period match raises interrupt and DMA event
// RULE4: two events in 64-bit, four in dual; the code gives one event in 64-bit mode and two in the dual modes
// RULE5: two external clock inputs as count sources
// RULE6: two timer output pins, usable as clock
// RULE7: unserviced watchdog timeout asserts device reset
// RULE8: watchdog timeout may also interrupt the CPU
// RULE9: watchdog counts internal clock, drives no pins
// RULE10: chained: low half prescales the high half
// RULE11: period match reloads zero, counting continues
`timescale 1ns/10ps
`default_nettype none
module dmtw_timer_top (
    input wire logic core_clk,
    input wire logic resetn,
    input wire dmtw_pkg::dmtw_mode_t timerMode,
    input wire logic timerRun,
    input wire logic [1:0] extClkSel,
    input wire logic [1:0] extClkPin,
    input wire logic [31:0] periodLo,
    input wire logic [31:0] periodHi,
    input wire logic [1:0] irqEnable,
    input wire logic [1:0] dmaEnable,
    output logic [1:0] timerIrq,
    output logic [1:0] dmaSyncEvent,
    output logic [1:0] timerOutPin,
    input wire logic wdEnable,
    input wire logic wdService,
    input wire logic wdIrqEnable,
    input wire logic [63:0] wdPeriod,
    output logic wdResetReq,
    output logic wdIrq
);
    dmtw_half_if loIf ();
    dmtw_half_if hiIf ();

    logic [1:0] extSync1_ff;
    logic [1:0] extSync2_ff;
    logic [1:0] extLast_ff;
    logic [1:0] timerIrq_ff;
    logic [1:0] dmaSync_ff;
    logic [1:0] timerOut_ff;
    logic [63:0] wdCount_ff;
    logic wdExpired_ff;
    logic wdIrq_ff;

    // mode decode
    wire is64 = (timerMode == dmtw_pkg::DMTW_MODE_64); // RULE2
    wire isChained = (timerMode == dmtw_pkg::DMTW_MODE_CHAINED); // RULE2
    // source ticks: internal clock or synchronised external rising edge
    wire [1:0] extRise = extSync2_ff & ~extLast_ff;
    wire [1:0] srcTick = {extClkSel[1] ? extRise[1] : timerRun,
                          extClkSel[0] ? extRise[0] : timerRun}; // RULE5
    wire loTick = srcTick[0] & timerRun;
    wire loMatch = loIf.tick & loIf.atPeriod;
    wire hiMatch = hiIf.tick & hiIf.atPeriod;
    wire match64 = loTick & (loIf.count == periodLo) & (hiIf.count == periodHi);

    // half control per mode
    assign loIf.tick = loTick;
    assign loIf.period = is64 ? dmtw_pkg::DMTW_HALF_MAX : periodLo; // RULE1
    assign loIf.clear = is64 ? match64 : loMatch; // RULE11
    assign hiIf.period = periodHi;
    assign hiIf.tick = is64 ? (loTick & loIf.atPeriod & ~match64) : // RULE1
                       isChained ? loMatch : (srcTick[1] & timerRun); // RULE10
    assign hiIf.clear = is64 ? match64 : hiMatch; // RULE11

    // events: one per half in dual modes, one in 64-bit mode
    wire [1:0] timerEvt = is64 ? {1'b0, match64} : {hiMatch, loMatch}; // RULE4

    dmtw_half_counter loCnt (
        .core_clk(core_clk),
        .resetn(resetn),
        .half(loIf.cnt)
    );

    dmtw_half_counter hiCnt (
        .core_clk(core_clk),
        .resetn(resetn),
        .half(hiIf.cnt)
    );

    // external clock synchronisers and edge history
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            extSync1_ff <= 2'h0;
            extSync2_ff <= 2'h0;
            extLast_ff <= 2'h0;
        end else begin
            extSync1_ff <= extClkPin;
            extSync2_ff <= extSync1_ff;
            extLast_ff <= extSync2_ff;
        end
    end

    // event outputs and clock-out toggles
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            timerIrq_ff <= 2'h0;
            dmaSync_ff <= 2'h0;
            timerOut_ff <= 2'h0;
        end else begin
            timerIrq_ff <= timerEvt & irqEnable; // RULE3
            dmaSync_ff <= timerEvt & dmaEnable; // RULE3
            timerOut_ff <= timerOut_ff ^ timerEvt; // RULE6
        end
    end

    assign timerIrq = timerIrq_ff;
    assign dmaSyncEvent = dmaSync_ff;
    assign timerOutPin = timerOut_ff;

    // watchdog: core clock only, service restarts the interval
    wire wdTimeout = wdEnable & ~wdExpired_ff & ~wdService & (wdCount_ff == wdPeriod);
    wire [63:0] nxt_wdCount = (wdService | ~wdEnable) ? dmtw_pkg::DMTW_WD_RST :
                              (wdExpired_ff | wdTimeout) ? wdCount_ff :
                              wdCount_ff + dmtw_pkg::DMTW_WD_ONE; // RULE9

    // watchdog state; expiry holds until device reset
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wdCount_ff <= dmtw_pkg::DMTW_WD_RST;
            wdExpired_ff <= 1'b0;
            wdIrq_ff <= 1'b0;
        end else begin
            wdCount_ff <= nxt_wdCount;
            wdExpired_ff <= wdExpired_ff | wdTimeout; // RULE7
            wdIrq_ff <= wdTimeout & wdIrqEnable; // RULE8
        end
    end

    assign wdResetReq = wdExpired_ff;
    assign wdIrq = wdIrq_ff;

    // watchdog checks: expiry, service, interrupt gating
    a_wd_reset_req: assert property (@(posedge core_clk) disable iff (!resetn) // RULE7
        wdTimeout |=> wdResetReq ##1 wdResetReq)
        else $error("watchdog reset not held after timeout");
    a_wd_irq_pulse: assert property (@(posedge core_clk) disable iff (!resetn) // RULE8
        (wdTimeout && wdIrqEnable) |=> wdIrq ##1 !wdIrq)
        else $error("watchdog interrupt not a single pulse");
    a_wd_count_step: assert property (@(posedge core_clk) disable iff (!resetn) // RULE9
        (wdEnable && !wdService && !wdExpired_ff && !wdTimeout)
        |=> wdCount_ff == $past(wdCount_ff) + dmtw_pkg::DMTW_WD_ONE)
        else $error("watchdog did not advance one per core clock");
    a_wd_expiry_cause: assert property (@(posedge core_clk) disable iff (!resetn) // RULE7
        $rose(wdResetReq) |-> $past(wdTimeout))
        else $error("watchdog reset request without a timeout");
    a_wd_service_clear: assert property (@(posedge core_clk) disable iff (!resetn) // RULE7
        wdService |=> wdCount_ff == dmtw_pkg::DMTW_WD_RST)
        else $error("watchdog service did not restart the interval");
    a_wd_irq_gated: assert property (@(posedge core_clk) disable iff (!resetn) // RULE8
        wdIrq |-> $past(wdTimeout && wdIrqEnable))
        else $error("watchdog interrupt without an enabled timeout");
    a_wd_idle_zero: assert property (@(posedge core_clk) disable iff (!resetn) // RULE7
        !wdEnable |=> wdCount_ff == dmtw_pkg::DMTW_WD_RST && !wdIrq)
        else $error("disabled watchdog kept counting");
    // event outputs: one cycle after an enabled match, never otherwise
    a_irq_on_match: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
        (timerEvt[0] && irqEnable[0]) |=> timerIrq[0])
        else $error("period match gave no interrupt");
    a_irq_match_hi: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
        (timerEvt[1] && irqEnable[1]) |=> timerIrq[1])
        else $error("high period match gave no interrupt");
    a_dma_match_lo: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
        (timerEvt[0] && dmaEnable[0]) |=> dmaSyncEvent[0])
        else $error("low period match gave no dma event");
    a_irq_gated_lo: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
        timerIrq[0] |-> $past(timerEvt[0] && irqEnable[0]))
        else $error("low interrupt without an enabled match");
    a_irq_gated_hi: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
        timerIrq[1] |-> $past(timerEvt[1] && irqEnable[1]))
        else $error("high interrupt without an enabled match");
    a_dma_gated_lo: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
        dmaSyncEvent[0] |-> $past(timerEvt[0] && dmaEnable[0]))
        else $error("low dma event without an enabled match");
    a_dma_gated_hi: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
        dmaSyncEvent[1] |-> $past(timerEvt[1] && dmaEnable[1]))
        else $error("high dma event without an enabled match");
    a_dma_on_match: assert property (@(posedge core_clk) disable iff (!resetn) // RULE3
        (timerEvt[1] && dmaEnable[1]) |=> dmaSyncEvent[1])
        else $error("period match gave no dma event");
    a_mode64_events: assert property (@(posedge core_clk) disable iff (!resetn) // RULE4
        $past(is64) |-> !timerIrq[1] && !dmaSyncEvent[1])
        else $error("second event fired in 64-bit mode");
    a_out_toggle: assert property (@(posedge core_clk) disable iff (!resetn) // RULE6
        timerEvt[1] |=> timerOutPin[1] != $past(timerOutPin[1]))
        else $error("timer output did not toggle on match");
    a_out_toggle_lo: assert property (@(posedge core_clk) disable iff (!resetn) // RULE6
        timerEvt[0] |=> timerOutPin[0] != $past(timerOutPin[0]))
        else $error("low timer output did not toggle on match");
    a_out_hold: assert property (@(posedge core_clk) disable iff (!resetn) // RULE6
        timerEvt == 2'h0 |=> $stable(timerOutPin))
        else $error("timer output moved without a match");
    a_chain_advance: assert property (@(posedge core_clk) disable iff (!resetn) // RULE10
        (isChained && loMatch && !hiMatch)
        |=> hiIf.count == $past(hiIf.count) + dmtw_pkg::DMTW_HALF_ONE
            && loIf.count == dmtw_pkg::DMTW_HALF_RST)
        else $error("chained high half did not advance on prescale match");
    a_carry_64: assert property (@(posedge core_clk) disable iff (!resetn) // RULE1
        (is64 && loTick && loIf.atPeriod && !match64)
        |=> hiIf.count == $past(hiIf.count) + dmtw_pkg::DMTW_HALF_ONE)
        else $error("64-bit carry into high half lost");
    a_reload_64: assert property (@(posedge core_clk) disable iff (!resetn) // RULE11
        match64 |=> loIf.count == dmtw_pkg::DMTW_HALF_RST && hiIf.count == dmtw_pkg::DMTW_HALF_RST)
        else $error("64-bit counter did not reload to zero");
    // split halves: each reloads on its own match and, when unchained, counts on its own
    a_lo_reload: assert property (@(posedge core_clk) disable iff (!resetn) // RULE11
        (!is64 && loMatch) |=> loIf.count == dmtw_pkg::DMTW_HALF_RST)
        else $error("low half did not reload to zero");
    a_hi_reload: assert property (@(posedge core_clk) disable iff (!resetn) // RULE11
        (!is64 && hiMatch) |=> hiIf.count == dmtw_pkg::DMTW_HALF_RST)
        else $error("high half did not reload to zero");
    a_split_hi_count: assert property (@(posedge core_clk) disable iff (!resetn) // RULE1
        (timerMode == dmtw_pkg::DMTW_MODE_UNCHAINED && !extClkSel[1] && timerRun && !hiMatch)
        |=> hiIf.count == $past(hiIf.count) + dmtw_pkg::DMTW_HALF_ONE)
        else $error("unchained high half did not count on its own");
    a_ext_idle: assert property (@(posedge core_clk) disable iff (!resetn) // RULE5
        (extClkSel[0] && !extRise[0] && !loIf.clear) |=> $stable(loIf.count))
        else $error("low half counted without an external edge");
    a_run_gate: assert property (@(posedge core_clk) disable iff (!resetn) // RULE5
        !timerRun |=> $stable(loIf.count) && $stable(hiIf.count))
        else $error("stopped timer still counted");
endmodule : dmtw_timer_top
`default_nettype wire

// >>> test/dmtw_ext_clk_model.sv
// external clock source driving the two counting pins
`timescale 1ns/10ps
`default_nettype none
module dmtw_ext_clk_model (
    input wire logic clkOn,
    output logic [1:0] extClkPin
);
    // 40 ns clock while on, held low while off
    initial begin
        extClkPin = 2'b00;
        forever begin
            #3;
            extClkPin = clkOn ? ~extClkPin : 2'b00;
            #17;
        end
    end
endmodule : dmtw_ext_clk_model
`default_nettype wire

// >>> test/tb_dual_mode_timer_watchdog.sv
// self-checking bench for the dual mode timer and watchdog
`timescale 1ns/10ps
`default_nettype none
module tb_dual_mode_timer_watchdog;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    dmtw_pkg::dmtw_mode_t timerMode = dmtw_pkg::DMTW_MODE_UNCHAINED;
    logic timerRun = 1'b0, clkOn = 1'b0, wdEnable = 1'b0, wdService = 1'b0;
    logic wdIrqEnable = 1'b1, wdResetReq, wdIrq;
    logic [1:0] extClkSel = 2'b00, extClkPin, irqEnable = 2'b11, dmaEnable = 2'b11;
    logic [1:0] timerIrq, dmaSyncEvent, timerOutPin;
    logic [31:0] periodLo = 32'h0000_0001, periodHi = 32'h0000_0001;
    logic [63:0] wdPeriod = 64'h0000_0000_0000_0004;
    int errors = 0, cmpCount = 0, a, b, n;

    dmtw_timer_top u_dmtw_timer_top (.core_clk(core_clk), .resetn(resetn),
        .timerMode(timerMode), .timerRun(timerRun), .extClkSel(extClkSel),
        .extClkPin(extClkPin), .periodLo(periodLo), .periodHi(periodHi),
        .irqEnable(irqEnable), .dmaEnable(dmaEnable), .timerIrq(timerIrq),
        .dmaSyncEvent(dmaSyncEvent), .timerOutPin(timerOutPin), .wdEnable(wdEnable),
        .wdService(wdService), .wdIrqEnable(wdIrqEnable), .wdPeriod(wdPeriod),
        .wdResetReq(wdResetReq), .wdIrq(wdIrq));
    dmtw_ext_clk_model u_dmtw_ext_clk_model (.clkOn(clkOn), .extClkPin(extClkPin));

    // 125 MHz core clock
    initial begin
        forever #4 core_clk = ~core_clk;
    end

    task automatic tick; // step past the edge so its updates land
        @(posedge core_clk);
        #1;
    endtask : tick

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        cmpCount++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", cmpCount, errors);
        if (errors == 0 && cmpCount > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish

    task automatic rst; // reset held for 8 cycles
        resetn = 1'b0;
        repeat (8) tick;
        resetn = 1'b1;
    endtask : rst

    function automatic int evGap(input int p, input int scale);
        return (p + 1) * scale;
    endfunction : evGap

    // cycles between two events of one index, with dma and pin alongside
    task automatic gap(input int i, input int exp);
        int k;
        logic pin;
        k = 0;
        while (timerIrq[i] !== 1'b1 && k < 5000) begin
            tick;
            k++;
        end
        pin = timerOutPin[i];
        k = 0;
        do begin
            tick;
            k++;
        end while (timerIrq[i] !== 1'b1 && k < 5000);
        chk("event gap", exp, k);
        chk("dma event", dmaEnable[i], dmaSyncEvent[i]);
        chk("out pin", !pin, timerOutPin[i]);
    endtask : gap

    task automatic run(input dmtw_pkg::dmtw_mode_t m, input int lo, input int hi);
        timerMode = m;
        periodLo = lo;
        periodHi = hi;
        rst;
        timerRun = 1'b1;
    endtask : run

    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        tally_and_finish;
    end

    initial begin
        void'($urandom(2439));
        a = $urandom_range(12, 1);
        b = $urandom_range(12, 1);
        run(dmtw_pkg::DMTW_MODE_UNCHAINED, a, b);
        gap(0, evGap(a, 1));
        gap(1, evGap(b, 1));
        run(dmtw_pkg::DMTW_MODE_64, b, 0);
        gap(0, evGap(b, 1));
        chk("hi event idle", 0, timerIrq[1]);
        dmaEnable = 2'h1;
        run(dmtw_pkg::DMTW_MODE_CHAINED, a, b);
        gap(0, evGap(a, 1));
        gap(1, evGap(b, a + 1));
        clkOn = 1'b1;
        extClkSel = 2'b11;
        dmaEnable = 2'h2;
        run(dmtw_pkg::DMTW_MODE_UNCHAINED, 1, 2);
        gap(0, evGap(1, 5));
        gap(1, evGap(2, 5));
        // external edges keep coming while the timer is stopped
        timerRun = 1'b0;
        wdPeriod = $urandom_range(20, 4);
        rst;
        n = 0;
        repeat (20) begin
            tick;
            n = n | timerIrq | dmaSyncEvent | timerOutPin;
        end
        chk("run gate", 0, n);
        wdEnable = 1'b1;
        // serviced in time: no expiry
        repeat (3) begin
            wdService = 1'b1;
            tick;
            wdService = 1'b0;
            repeat (wdPeriod - 1) tick;
        end
        chk("wd held off", 0, wdResetReq);
        wdService = 1'b1;
        tick;
        wdService = 1'b0;
        n = 0;
        while (wdResetReq !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        chk("wd timeout", wdPeriod + 1, n);
        chk("wd irq", 1, wdIrq);
        wdService = 1'b1;
        tick;
        wdService = 1'b0;
        chk("wd irq pulse", 0, wdIrq);
        chk("wd sticky", 1, wdResetReq);
        // reset clears the expiry; a masked timeout gives no interrupt
        wdIrqEnable = 1'b0;
        rst;
        chk("wd reset cleared", 0, wdResetReq);
        n = 0;
        while (wdResetReq !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        chk("wd timeout masked", wdPeriod + 1, n);
        chk("wd irq masked", 0, wdIrq);
        tally_and_finish;
    end
endmodule : tb_dual_mode_timer_watchdog
`default_nettype wire
